/* File: common/lmm_exec_pkg.sv */
// types of the load, multiply-accumulate and move execution block
// assumes the issuing core decodes opcodes into op_t
package lmm_exec_pkg;
	typedef enum logic [4:0] {
		OP_ISYNC, OP_LB, OP_LHZ, OP_LHA, OP_LHBR, OP_LW, OP_LWBR,
		OP_LWARX, OP_LMW, OP_LSWI, OP_LSWX, OP_LA, OP_LI, OP_LIS,
		OP_MAC, OP_MCRF, OP_MCRXR, OP_MFCR, OP_MFMSR, OP_MFDCR,
		OP_MFSPR, OP_MFTB
	} op_t;
	typedef enum logic [1:0] {
		HALF_CROSS, HALF_HIGH, HALF_LOW
	} mac_half_t;
	typedef enum {
		ST_IDLE, ST_MEM, ST_SIDE
	} st_t;
endpackage

/* File: common/lmm_exec_regs.svh */
// constants of the load, multiply-accumulate and move execution block
// assumes a big-endian memory answer, right-justified in the data word
// Behaviour
// - context sync discards prefetched instructions; later ones run in new context
// - byte load puts one byte in low byte, upper 24 bits zero
// - zero-extending halfword load fills low 16 bits, clears upper 16
// - algebraic halfword load sign-extends the halfword to 32 bits
// - update forms also write the effective address back to base register
// - reversed halfword: byte at address plus one in bits 16-23
// - reversed word: bytes at plus 3,2,1,0 from most to least significant
// - load multiple fills target up to register 31; base kept unless 31
// - immediate string count is its field, or 32 when zero
// - string loads wrap 31 to 0; base or index kept unless final
// - indexed string count comes from exception register; zero count leaves target
// - load and reserve loads the word and sets the reservation bit
// - load immediate shifted puts immediate in upper half, low half zero
// - cross multiply-accumulate uses bits 16-31 times 0-15, keeps low 32
// - high variants multiply bits 0-15 of both sources, signed or unsigned
// - low variants multiply bits 16-31 of both sources
// - signed saturation loads old sign followed by 31 inverted sign bits
// - unsigned saturation forces all ones on carry out of 32 bits
// - condition field move copies selected source field into destination field
// - exception-to-field move copies top bits then clears three flag bits
// - move-from copies condition, machine state or device control register
// - special register move copies the selected special register
// - time base read selects half by number; default number reads low half
`ifndef LMM_EXEC_REGS_SVH
`define LMM_EXEC_REGS_SVH
`define RESET_WORD 32'h0000_0000
`define LAST_GPR 5'h1f
`define SZ_BYTE 3'h1
`define SZ_HALF 3'h2
`define WORD_BYTES 3'h4
`define STR_DEFAULT 7'h20
`define ADDR_STEP 32'h0000_0004
`define XER_TBC 6:0
`define XER_TOP 31:28
`define XER_SOC 31:29
`define TB_LOW_SEL 10'h10c
`define TB_UP_SEL 10'h10d
`endif

/* File: dv/lmm_mem_model.sv */
// memory and special/device register responder for the execution block
// assumes requests are held until acknowledged, on the one core clock
`timescale 1ns/1ps
`default_nettype none
module lmm_mem_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic req_in,
	input wire logic [31:0] addr_in,
	input wire logic [2:0] size_in,
	input wire logic side_req_in,
	input wire logic side_dcr_in,
	input wire logic [9:0] side_num_in,
	output logic ack_out,
	output logic [31:0] rdata_out,
	output logic side_ack_out,
	output logic [31:0] side_rdata_out
);
	logic [1:0] wait_q;
	logic [31:0] word;
	// byte at a is a[7:0]^96, right-justified, first byte most significant
	always_comb begin
		word = 32'h0;
		for (int i = 0; i < 4; i++)
			if (i < 32'(size_in))
				word = {word[23:0], 8'(addr_in + 32'(i)) ^ 8'h96};
	end
	// data lines flip when idle so stale values never look valid
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_q <= 2'h0;
			ack_out <= 1'b0;
			side_ack_out <= 1'b0;
			rdata_out <= 32'h0;
			side_rdata_out <= 32'h0;
		end else begin
			ack_out <= 1'b0;
			side_ack_out <= 1'b0;
			rdata_out <= ~rdata_out;
			side_rdata_out <= ~side_rdata_out;
			if ((req_in || side_req_in) && !ack_out && !side_ack_out) begin
				if (slow_in && wait_q != 2'h3) begin
					wait_q <= wait_q + 2'h1;
				end else begin
					wait_q <= 2'h0;
					ack_out <= req_in;
					side_ack_out <= side_req_in && !req_in;
					rdata_out <= word;
					side_rdata_out <= {side_dcr_in, 21'h0abcde, side_num_in};
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/load_mac_move_instr_exec_tb_top.sv */
// self-checking bench for the load, multiply-accumulate and move block
// assumes the responder model answers memory and side reads
`timescale 1ns/1ps
`default_nettype none
module load_mac_move_instr_exec_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic issue = 1'b0;
	lmm_exec_pkg::op_t op = lmm_exec_pkg::OP_ISYNC;
	logic [4:0] tgt = 5'h0, base = 5'h0, idx = 5'h0, cnt = 5'h0;
	logic [4:0] raddr = 5'h0, gwa = 5'h0;
	logic indexed = 1'b0, update = 1'b0, uns = 1'b0, sat = 1'b0;
	logic resv_clr = 1'b0, gwe = 1'b0, xwe = 1'b0, slow = 1'b0;
	logic [15:0] imm = 16'h0;
	logic [2:0] fdst = 3'h0, fsrc = 3'h0;
	lmm_exec_pkg::mac_half_t half = lmm_exec_pkg::HALF_CROSS;
	logic [9:0] special_purpose_reg = 10'h0;
	logic [31:0] machine_state_reg = 32'h0, time_base_low = 32'h0, tbh = 32'h0;
	logic [31:0] gwd = 32'h0, xwd = 32'h0;
	logic busy, done, flush, reserve, mreq, sreq, sdcr, mack, sack;
	logic [31:0] maddr, cr, fixed_exception_reg, grd, mrd, srd;
	logic [2:0] msize;
	logic [9:0] snum;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic flushed;
	localparam logic [31:0] mac_a = 32'h7fff_8000;
	localparam logic [31:0] mac_b = 32'h7fff_0002;

	initial forever #10 clk = ~clk;

	load_mac_move_instr_exec u_load_mac_move_instr_exec (.MCLK_IN(clk),
		.RSTN_IN(rstn), .ISSUE_IN(issue), .OP_IN(op), .TGT_IN(tgt),
		.BASE_IN(base), .IDX_IN(idx), .INDEXED_IN(indexed),
		.UPDATE_IN(update), .IMM_IN(imm), .STR_CNT_IN(cnt),
		.FLD_DST_IN(fdst), .FLD_SRC_IN(fsrc), .MAC_HALF_IN(half),
		.MAC_UNS_IN(uns), .MAC_SAT_IN(sat), .SPR_NUM_IN(special_purpose_reg), .MSR_IN(machine_state_reg),
		.TB_LOW_IN(time_base_low), .TB_HIGH_IN(tbh), .MEM_ACK_IN(mack),
		.MEM_RDATA_IN(mrd), .SIDE_ACK_IN(sack), .SIDE_RDATA_IN(srd),
		.RESV_CLR_IN(resv_clr), .GPR_WE_IN(gwe), .GPR_WADDR_IN(gwa),
		.GPR_WDATA_IN(gwd), .XER_WE_IN(xwe), .XER_WDATA_IN(xwd),
		.GPR_RADDR_IN(raddr), .BUSY_OUT(busy), .DONE_OUT(done),
		.FLUSH_OUT(flush), .RESERVE_OUT(reserve), .MEM_REQ_OUT(mreq),
		.MEM_ADDR_OUT(maddr), .MEM_SIZE_OUT(msize), .SIDE_REQ_OUT(sreq),
		.SIDE_DCR_OUT(sdcr), .SIDE_NUM_OUT(snum), .CR_OUT(cr),
		.XER_OUT(fixed_exception_reg), .GPR_RDATA_OUT(grd));

	lmm_mem_model u_lmm_mem_model (.clk_in(clk), .rstn_in(rstn),
		.slow_in(slow), .req_in(mreq), .addr_in(maddr), .size_in(msize),
		.side_req_in(sreq), .side_dcr_in(sdcr), .side_num_in(snum),
		.ack_out(mack), .rdata_out(mrd), .side_ack_out(sack),
		.side_rdata_out(srd));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic put(input logic [4:0] n, input logic [31:0] v);
		@(posedge clk);
		gwe <= 1'b1;
		gwa <= n;
		gwd <= v;
		@(posedge clk);
		gwe <= 1'b0;
	endtask

	task automatic setx(input logic [31:0] v);
		@(posedge clk);
		xwe <= 1'b1;
		xwd <= v;
		@(posedge clk);
		xwe <= 1'b0;
	endtask

	// read port is registered, so two edges pass before sampling
	task automatic reg_is(input logic [4:0] n, input logic [31:0] exp);
		@(posedge clk);
		raddr <= n;
		repeat (2) @(posedge clk);
		#1 chk(grd, exp);
	endtask

	task automatic run(input lmm_exec_pkg::op_t o, input logic [4:0] t,
		input logic [4:0] b, input logic [4:0] x, input logic [15:0] im,
		input logic [1:0] f);
		@(posedge clk);
		issue <= 1'b1;
		op <= o;
		tgt <= t;
		base <= b;
		idx <= x;
		imm <= im;
		{indexed, update} <= f;
		@(posedge clk);
		issue <= 1'b0;
		flushed = 1'b0;
		// single-cycle ops finish at the issue edge: look before waiting
		for (int i = 0; i < 200; i++) begin
			#1;
			if (flush === 1'b1)
				flushed = 1'b1;
			if (done === 1'b1)
				break;
			@(posedge clk);
		end
		chk({31'h0, done}, 32'h1);
	endtask

	task automatic t_imm();
		run(lmm_exec_pkg::OP_LI, 5'h1, 5'h0, 5'h0, 16'h8001, 2'h0);
		reg_is(5'h1, 32'hffff_8001);
		run(lmm_exec_pkg::OP_LIS, 5'h2, 5'h0, 5'h0, 16'h8001, 2'h0);
		reg_is(5'h2, 32'h8001_0000);
		run(lmm_exec_pkg::OP_LA, 5'h1, 5'h3, 5'h0, 16'h0010, 2'h0);
		reg_is(5'h1, 32'h0000_1010);
		run(lmm_exec_pkg::OP_ISYNC, 5'h0, 5'h0, 5'h0, 16'h0, 2'h0);
		chk({31'h0, flushed}, 32'h1);
		$display("immediate test done");
	endtask

	task automatic t_load();
		lmm_exec_pkg::op_t ops[6] = '{lmm_exec_pkg::OP_LB,
			lmm_exec_pkg::OP_LHZ, lmm_exec_pkg::OP_LHA,
			lmm_exec_pkg::OP_LHBR, lmm_exec_pkg::OP_LW,
			lmm_exec_pkg::OP_LWBR};
		logic [31:0] e[6] = '{32'h94, 32'h9495, 32'hffff_9495, 32'h9594,
			32'h9495_9293, 32'h9392_9594};
		// displacement and index both give address 0f02
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			slow <= i[1];
			run(ops[i], 5'h5, 5'h3, 5'h4, 16'hff02, {i[0], 1'b0});
			reg_is(5'h5, e[i]);
		end
		run(lmm_exec_pkg::OP_LW, 5'h6, 5'h3, 5'h4, 16'h0, 2'h3);
		reg_is(5'h3, 32'h0000_0f02);
		run(lmm_exec_pkg::OP_LB, 5'h7, 5'h0, 5'h0, 16'h0f05, 2'h0);
		reg_is(5'h7, 32'h93);
		run(lmm_exec_pkg::OP_LWARX, 5'h8, 5'h0, 5'h4, 16'h0, 2'h2);
		reg_is(5'h8, 32'h9495_9293);
		chk({31'h0, reserve}, 32'h1);
		@(posedge clk);
		resv_clr <= 1'b1;
		@(posedge clk);
		resv_clr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, reserve}, 32'h0);
		$display("load test done");
	endtask

	task automatic t_multi();
		put(5'h1e, 32'h2000);
		run(lmm_exec_pkg::OP_LMW, 5'h1d, 5'h1e, 5'h0, 16'h10, 2'h0);
		reg_is(5'h1d, 32'h8687_8485);
		reg_is(5'h1f, 32'h8e8f_8c8d);
		reg_is(5'h1e, 32'h2000);
		@(posedge clk);
		cnt <= 5'h9;
		run(lmm_exec_pkg::OP_LSWI, 5'h1f, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h0, 32'h9293_9091);
		reg_is(5'h1, 32'h9e00_0000);
		put(5'hc, 32'h100);
		@(posedge clk);
		cnt <= 5'h0;
		run(lmm_exec_pkg::OP_LSWI, 5'h8, 5'hc, 5'h0, 16'h0, 2'h0);
		reg_is(5'hf, 32'h8a8b_8889);
		reg_is(5'hc, 32'h100);
		put(5'h14, 32'h55);
		setx(32'h0);
		run(lmm_exec_pkg::OP_LSWX, 5'h14, 5'h0, 5'h3, 16'h0, 2'h2);
		reg_is(5'h14, 32'h55);
		setx(32'h5);
		run(lmm_exec_pkg::OP_LSWX, 5'h14, 5'h0, 5'h3, 16'h0, 2'h2);
		reg_is(5'h15, 32'h9000_0000);
		$display("multiple and string test done");
	endtask

	function automatic logic [31:0] macx(input logic [3:0] c,
		input logic [31:0] rt);
		logic [15:0] a, b;
		logic [31:0] p;
		logic [32:0] t;
		a = (c[3:2] == 2'h1) ? mac_a[31:16] : mac_a[15:0];
		b = (c[3:2] == 2'h2) ? mac_b[15:0] : mac_b[31:16];
		p = c[1] ? {16'h0, a} * {16'h0, b} :
			{{16{a[15]}}, a} * {{16{b[15]}}, b};
		t = {1'b0, p} + {1'b0, rt};
		if (c[0] && c[1] && t[32])
			return 32'hffff_ffff;
		if (c[0] && !c[1] && p[31] == rt[31] && rt[31] != t[31])
			return {rt[31], {31{!rt[31]}}};
		return t[31:0];
	endfunction

	task automatic t_mac();
		// half, unsigned, saturate per case
		logic [3:0] c[6] = '{4'h0, 4'h6, 4'h8, 4'h5, 4'h7, 4'h9};
		logic [31:0] r[6] = '{32'h10, 32'h1, 32'h0, 32'h7fff_ff00,
			32'hffff_0000, 32'h8000_0000};
		put(5'h6, mac_a);
		put(5'h7, mac_b);
		for (int i = 0; i < 6; i++) begin
			put(5'h8, r[i]);
			@(posedge clk);
			half <= lmm_exec_pkg::mac_half_t'(c[i][3:2]);
			{uns, sat} <= c[i][1:0];
			run(lmm_exec_pkg::OP_MAC, 5'h8, 5'h6, 5'h7, 16'h0, 2'h0);
			reg_is(5'h8, macx(c[i], r[i]));
		end
		$display("multiply-accumulate test done");
	endtask

	task automatic t_move();
		@(posedge clk);
		machine_state_reg <= 32'h1234_8765;
		special_purpose_reg <= 10'h10d;
		time_base_low <= 32'h0bad_0001;
		tbh <= 32'h0bad_0002;
		run(lmm_exec_pkg::OP_MFMSR, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, 32'h1234_8765);
		run(lmm_exec_pkg::OP_MFTB, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, 32'h0bad_0002);
		@(posedge clk);
		special_purpose_reg <= 10'h10c;
		run(lmm_exec_pkg::OP_MFTB, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, 32'h0bad_0001);
		run(lmm_exec_pkg::OP_MFSPR, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, {1'b0, 21'h0abcde, 10'h10c});
		run(lmm_exec_pkg::OP_MFDCR, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, {1'b1, 21'h0abcde, 10'h10c});
		setx(32'hf000_0005);
		@(posedge clk);
		fdst <= 3'h2;
		fsrc <= 3'h2;
		run(lmm_exec_pkg::OP_MCRXR, 5'h0, 5'h0, 5'h0, 16'h0, 2'h0);
		chk(fixed_exception_reg, 32'h1000_0005);
		chk(cr, 32'h00f0_0000);
		@(posedge clk);
		fdst <= 3'h5;
		run(lmm_exec_pkg::OP_MCRF, 5'h0, 5'h0, 5'h0, 16'h0, 2'h0);
		chk(cr, 32'h00f0_0f00);
		run(lmm_exec_pkg::OP_MFCR, 5'h9, 5'h0, 5'h0, 16'h0, 2'h0);
		reg_is(5'h9, 32'h00f0_0f00);
		$display("move test done");
	endtask

	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		put(5'h0, 32'h100);
		put(5'h3, 32'h1000);
		put(5'h4, 32'hffff_ff02);
		t_imm();
		t_load();
		t_multi();
		t_mac();
		t_move();
		conclude();
	end
endmodule
`default_nettype wire

/* File: rtl/load_mac_move_instr_exec.sv */
// execution of loads, halfword multiply-accumulate and register moves
// assumes issue, memory and side-register ports share MCLK_IN
`timescale 1ns/1ps
`default_nettype none
`include "lmm_exec_regs.svh"
module load_mac_move_instr_exec (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic ISSUE_IN,
	input wire lmm_exec_pkg::op_t OP_IN,
	input wire logic [4:0] TGT_IN,
	input wire logic [4:0] BASE_IN,
	input wire logic [4:0] IDX_IN,
	input wire logic INDEXED_IN,
	input wire logic UPDATE_IN,
	input wire logic [15:0] IMM_IN,
	input wire logic [4:0] STR_CNT_IN,
	input wire logic [2:0] FLD_DST_IN,
	input wire logic [2:0] FLD_SRC_IN,
	input wire lmm_exec_pkg::mac_half_t MAC_HALF_IN,
	input wire logic MAC_UNS_IN,
	input wire logic MAC_SAT_IN,
	input wire logic [9:0] SPR_NUM_IN,
	input wire logic [31:0] MSR_IN,
	input wire logic [31:0] TB_LOW_IN,
	input wire logic [31:0] TB_HIGH_IN,
	input wire logic MEM_ACK_IN,
	input wire logic [31:0] MEM_RDATA_IN,
	input wire logic SIDE_ACK_IN,
	input wire logic [31:0] SIDE_RDATA_IN,
	input wire logic RESV_CLR_IN,
	input wire logic GPR_WE_IN,
	input wire logic [4:0] GPR_WADDR_IN,
	input wire logic [31:0] GPR_WDATA_IN,
	input wire logic XER_WE_IN,
	input wire logic [31:0] XER_WDATA_IN,
	input wire logic [4:0] GPR_RADDR_IN,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic FLUSH_OUT,
	output logic RESERVE_OUT,
	output logic MEM_REQ_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	output logic [2:0] MEM_SIZE_OUT,
	output logic SIDE_REQ_OUT,
	output logic SIDE_DCR_OUT,
	output logic [9:0] SIDE_NUM_OUT,
	output logic [31:0] CR_OUT,
	output logic [31:0] XER_OUT,
	output logic [31:0] GPR_RDATA_OUT
);
	typedef struct packed {
		lmm_exec_pkg::st_t st;
		logic busy;
		logic done;
		logic flush;
		logic resv;
		logic mreq;
		logic [31:0] maddr;
		logic [2:0] msize;
		logic sreq;
		logic sdcr;
		logic [9:0] snum;
		lmm_exec_pkg::op_t op;
		logic [4:0] tgt;
		logic [4:0] base;
		logic [4:0] idx;
		logic upd;
		logic [31:0] ea;
		logic [4:0] cur;
		logic [4:0] last;
		logic [6:0] rem;
		logic [31:0] cr;
		logic [31:0] fixed_exception_reg;
		logic [31:0] rd;
		logic [31:0][31:0] gpr;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic wb_en;
	logic [4:0] wb_sel;
	logic [31:0] wb_val;
	logic [31:0] base_v;
	logic [31:0] off_v;
	logic [31:0] ea_c;
	logic [31:0] ra_v;
	logic [31:0] rb_v;
	logic [31:0] rt_v;
	logic [15:0] ha;
	logic [15:0] hb;
	logic [31:0] prod;
	logic [32:0] sum;
	logic [31:0] mac_v;
	logic [6:0] nbytes;
	logic [7:0] nb_p3;
	logic [4:0] last_c;
	logic [2:0] first_sz;
	logic [2:0] next_sz;
	logic [6:0] rem_n;
	logic prot;
	logic [31:0] d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.flush = 1'b0;
		wb_en = 1'b0;
		wb_sel = TGT_IN;
		wb_val = `RESET_WORD;
		d = MEM_RDATA_IN;
		// a zero base field reads as zero, not as register 0
		base_v = (BASE_IN == 5'h00) ? `RESET_WORD : s_q.gpr[BASE_IN];
		off_v = INDEXED_IN ? s_q.gpr[IDX_IN] : {{16{IMM_IN[15]}}, IMM_IN};
		if (OP_IN == lmm_exec_pkg::OP_LSWI)
			off_v = `RESET_WORD;
		ea_c = base_v + off_v;
		ra_v = s_q.gpr[BASE_IN];
		rb_v = s_q.gpr[IDX_IN];
		rt_v = s_q.gpr[TGT_IN];
		case (MAC_HALF_IN)
			lmm_exec_pkg::HALF_CROSS: begin
				ha = ra_v[15:0];
				hb = rb_v[31:16];
			end
			lmm_exec_pkg::HALF_HIGH: begin
				ha = ra_v[31:16];
				hb = rb_v[31:16];
			end
			default: begin
				ha = ra_v[15:0];
				hb = rb_v[15:0];
			end
		endcase
		if (MAC_UNS_IN)
			prod = {16'h0000, ha} * {16'h0000, hb};
		else
			prod = 32'($signed(ha)) * 32'($signed(hb));
		sum = {1'b0, prod} + {1'b0, rt_v};
		mac_v = sum[31:0];
		if (MAC_SAT_IN && MAC_UNS_IN)
			mac_v = sum[31:0] | {32{sum[32]}};
		else if (MAC_SAT_IN && prod[31] == rt_v[31] && rt_v[31] != sum[31])
			mac_v = {rt_v[31], {31{~rt_v[31]}}};
		if (OP_IN == lmm_exec_pkg::OP_LSWI)
			nbytes = (STR_CNT_IN == 5'h00) ? `STR_DEFAULT
				: {2'b00, STR_CNT_IN};
		else
			nbytes = s_q.fixed_exception_reg[`XER_TBC];
		nb_p3 = {1'b0, nbytes} + 8'h03;
		last_c = TGT_IN + nb_p3[6:2] - 5'h01;
		first_sz = (nbytes >= 7'h04) ? `WORD_BYTES : nbytes[2:0];
		rem_n = s_q.rem - {4'h0, s_q.msize};
		next_sz = (rem_n >= 7'h04) ? `WORD_BYTES : rem_n[2:0];
		// base and index stay intact until the last register of a string
		prot = s_q.cur != s_q.last && ((s_q.base != 5'h00
			&& s_q.cur == s_q.base) || (s_q.op == lmm_exec_pkg::OP_LSWX
			&& s_q.cur == s_q.idx));
		if (GPR_WE_IN)
			s_d.gpr[GPR_WADDR_IN] = GPR_WDATA_IN;
		if (XER_WE_IN)
			s_d.fixed_exception_reg = XER_WDATA_IN;
		if (RESV_CLR_IN)
			s_d.resv = 1'b0;
		case (s_q.st)
			lmm_exec_pkg::ST_IDLE: begin
				if (ISSUE_IN) begin
					s_d.op = OP_IN;
					s_d.tgt = TGT_IN;
					s_d.base = BASE_IN;
					s_d.idx = IDX_IN;
					s_d.upd = UPDATE_IN;
					s_d.ea = ea_c;
					s_d.maddr = ea_c;
					s_d.cur = TGT_IN;
					s_d.msize = `WORD_BYTES;
					s_d.done = 1'b1;
					case (OP_IN)
						lmm_exec_pkg::OP_ISYNC:
							s_d.flush = 1'b1;
						lmm_exec_pkg::OP_LB, lmm_exec_pkg::OP_LHZ,
						lmm_exec_pkg::OP_LHA, lmm_exec_pkg::OP_LHBR,
						lmm_exec_pkg::OP_LW, lmm_exec_pkg::OP_LWBR,
						lmm_exec_pkg::OP_LWARX,
						lmm_exec_pkg::OP_LMW: begin
							s_d.done = 1'b0;
							s_d.busy = 1'b1;
							s_d.mreq = 1'b1;
							s_d.st = lmm_exec_pkg::ST_MEM;
							// lets the base guard below cover load multiple too
							if (OP_IN == lmm_exec_pkg::OP_LMW)
								s_d.last = `LAST_GPR;
							if (OP_IN == lmm_exec_pkg::OP_LB)
								s_d.msize = `SZ_BYTE;
							else if (OP_IN == lmm_exec_pkg::OP_LHZ
								|| OP_IN == lmm_exec_pkg::OP_LHA
								|| OP_IN == lmm_exec_pkg::OP_LHBR)
								s_d.msize = `SZ_HALF;
						end
						lmm_exec_pkg::OP_LSWI,
						lmm_exec_pkg::OP_LSWX: begin
							s_d.last = last_c;
							s_d.rem = nbytes;
							s_d.msize = first_sz;
							// zero count ends at once, target untouched
							if (nbytes != 7'h00) begin
								s_d.done = 1'b0;
								s_d.busy = 1'b1;
								s_d.mreq = 1'b1;
								s_d.st = lmm_exec_pkg::ST_MEM;
							end
						end
						lmm_exec_pkg::OP_LA: begin
							wb_en = 1'b1;
							wb_val = ea_c;
						end
						lmm_exec_pkg::OP_LI: begin
							wb_en = 1'b1;
							wb_val = {{16{IMM_IN[15]}}, IMM_IN};
						end
						lmm_exec_pkg::OP_LIS: begin
							wb_en = 1'b1;
							wb_val = {IMM_IN, 16'h0000};
						end
						lmm_exec_pkg::OP_MAC: begin
							wb_en = 1'b1;
							wb_val = mac_v;
						end
						lmm_exec_pkg::OP_MCRF:
							s_d.cr[{~FLD_DST_IN, 2'b00} +: 4] =
								s_q.cr[{~FLD_SRC_IN, 2'b00} +: 4];
						lmm_exec_pkg::OP_MCRXR: begin
							s_d.cr[{~FLD_DST_IN, 2'b00} +: 4] =
								s_q.fixed_exception_reg[`XER_TOP];
							s_d.fixed_exception_reg[`XER_SOC] = 3'h0;
						end
						lmm_exec_pkg::OP_MFCR: begin
							wb_en = 1'b1;
							wb_val = s_q.cr;
						end
						lmm_exec_pkg::OP_MFMSR: begin
							wb_en = 1'b1;
							wb_val = MSR_IN;
						end
						lmm_exec_pkg::OP_MFTB: begin
							wb_en = 1'b1;
							wb_val = (SPR_NUM_IN == `TB_UP_SEL)
								? TB_HIGH_IN : TB_LOW_IN;
						end
						lmm_exec_pkg::OP_MFDCR,
						lmm_exec_pkg::OP_MFSPR: begin
							s_d.done = 1'b0;
							s_d.busy = 1'b1;
							s_d.sreq = 1'b1;
							s_d.sdcr = OP_IN == lmm_exec_pkg::OP_MFDCR;
							s_d.snum = SPR_NUM_IN;
							s_d.st = lmm_exec_pkg::ST_SIDE;
						end
						default:
							s_d.done = 1'b1;
					endcase
				end
			end
			lmm_exec_pkg::ST_MEM: begin
				wb_sel = s_q.cur;
				if (MEM_ACK_IN) begin
					s_d.mreq = 1'b0;
					wb_en = 1'b1;
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.st = lmm_exec_pkg::ST_IDLE;
					case (s_q.op)
						lmm_exec_pkg::OP_LB:
							wb_val = {24'h000000, d[7:0]};
						lmm_exec_pkg::OP_LHZ:
							wb_val = {16'h0000, d[15:0]};
						lmm_exec_pkg::OP_LHA:
							wb_val = {{16{d[15]}}, d[15:0]};
						lmm_exec_pkg::OP_LHBR:
							wb_val = {16'h0000, d[7:0], d[15:8]};
						lmm_exec_pkg::OP_LWBR:
							wb_val = {d[7:0], d[15:8], d[23:16], d[31:24]};
						lmm_exec_pkg::OP_LWARX: begin
							wb_val = d;
							s_d.resv = 1'b1;
						end
						lmm_exec_pkg::OP_LMW: begin
							// base in range is skipped unless it is register 31
							wb_en = !prot;
							wb_val = d;
							if (s_q.cur != `LAST_GPR) begin
								s_d.done = 1'b0;
								s_d.busy = 1'b1;
								s_d.mreq = 1'b1;
								s_d.st = lmm_exec_pkg::ST_MEM;
								s_d.cur = s_q.cur + 5'h01;
								s_d.maddr = s_q.maddr + `ADDR_STEP;
							end
						end
						lmm_exec_pkg::OP_LSWI,
						lmm_exec_pkg::OP_LSWX: begin
							wb_en = !prot;
							wb_val = d << {`WORD_BYTES - s_q.msize, 3'b000};
							s_d.rem = rem_n;
							if (s_q.cur != s_q.last) begin
								s_d.done = 1'b0;
								s_d.busy = 1'b1;
								s_d.mreq = 1'b1;
								s_d.st = lmm_exec_pkg::ST_MEM;
								s_d.cur = s_q.cur + 5'h01;
								s_d.msize = next_sz;
								s_d.maddr = s_q.maddr + `ADDR_STEP;
							end
						end
						default:
							wb_val = d;
					endcase
				end
			end
			lmm_exec_pkg::ST_SIDE: begin
				wb_sel = s_q.tgt;
				if (SIDE_ACK_IN) begin
					s_d.sreq = 1'b0;
					wb_en = 1'b1;
					wb_val = SIDE_RDATA_IN;
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.st = lmm_exec_pkg::ST_IDLE;
				end
			end
			default:
				s_d.st = lmm_exec_pkg::ST_IDLE;
		endcase
		if (wb_en)
			s_d.gpr[wb_sel] = wb_val;
		// update write goes last; an update with base equal target is invalid
		if (s_q.st == lmm_exec_pkg::ST_MEM && MEM_ACK_IN && s_q.upd
			&& s_q.base != 5'h00 && s_q.op != lmm_exec_pkg::OP_LMW)
			s_d.gpr[s_q.base] = s_q.ea;
		s_d.rd = s_d.gpr[GPR_RADDR_IN];
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign BUSY_OUT = s_q.busy;
	assign DONE_OUT = s_q.done;
	assign FLUSH_OUT = s_q.flush;
	assign RESERVE_OUT = s_q.resv;
	assign MEM_REQ_OUT = s_q.mreq;
	assign MEM_ADDR_OUT = s_q.maddr;
	assign MEM_SIZE_OUT = s_q.msize;
	assign SIDE_REQ_OUT = s_q.sreq;
	assign SIDE_DCR_OUT = s_q.sdcr;
	assign SIDE_NUM_OUT = s_q.snum;
	assign CR_OUT = s_q.cr;
	assign XER_OUT = s_q.fixed_exception_reg;
	assign GPR_RDATA_OUT = s_q.rd;

	AST_FLUSH: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!s_q.busy && ISSUE_IN && OP_IN == lmm_exec_pkg::OP_ISYNC
		|=> FLUSH_OUT && DONE_OUT ##1 !FLUSH_OUT)
		else $error("sync did not flush for one cycle");
	AST_BYTE_ZERO: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_q.mreq && MEM_ACK_IN && s_q.op == lmm_exec_pkg::OP_LB
		|-> wb_en && wb_sel == s_q.tgt && wb_val[31:8] == 24'h000000)
		else $error("byte load left upper bits set");
	AST_HALF_ZERO: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_q.mreq && MEM_ACK_IN && s_q.op == lmm_exec_pkg::OP_LHZ
		|-> wb_en && wb_val == {16'h0000, MEM_RDATA_IN[15:0]})
		else $error("halfword load not zero extended");
	AST_HALF_SIGN: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_q.mreq && MEM_ACK_IN && s_q.op == lmm_exec_pkg::OP_LHA
		|-> wb_val[31:16] == {16{MEM_RDATA_IN[15]}})
		else $error("halfword load not sign extended");
	AST_LIS_LOW: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!s_q.busy && ISSUE_IN && OP_IN == lmm_exec_pkg::OP_LIS
		|-> wb_val == {IMM_IN, 16'h0000})
		else $error("shifted immediate misplaced");
	AST_RESERVE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_q.mreq && MEM_ACK_IN && s_q.op == lmm_exec_pkg::OP_LWARX
		|=> RESERVE_OUT && DONE_OUT)
		else $error("reserving load did not reserve");
	AST_XER_CLR: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!s_q.busy && ISSUE_IN && OP_IN == lmm_exec_pkg::OP_MCRXR && !XER_WE_IN
		|=> XER_OUT[`XER_SOC] == 3'h0
		&& XER_OUT[`XER_TBC] == $past(s_q.fixed_exception_reg[`XER_TBC]))
		else $error("flag bits not cleared");
	AST_USAT: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!s_q.busy && ISSUE_IN && OP_IN == lmm_exec_pkg::OP_MAC
		&& MAC_SAT_IN && MAC_UNS_IN && sum[32]
		|-> wb_val == 32'hffff_ffff)
		else $error("unsigned saturation missed");
	AST_ZERO_BASE: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!s_q.busy && ISSUE_IN && (OP_IN == lmm_exec_pkg::OP_LW
		|| OP_IN == lmm_exec_pkg::OP_LB)
		&& BASE_IN == 5'h00 && !INDEXED_IN
		|=> MEM_REQ_OUT && MEM_ADDR_OUT == {{16{$past(IMM_IN[15])}},
		$past(IMM_IN)})
		else $error("zero base not read as zero");
endmodule
`default_nettype wire
